/* hw/ilseq_pkg.sv */
// shared constants and carriers for the indicator lamp sequencer
// assumes a 100 MHz system clock; all lamp timing derives from a 1 ms tick
package ilseq_pkg;

   // ****************************************************************
   // timebase
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_PERIOD_MS = 1;
   localparam int TICK_CYCLES = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

   // ****************************************************************
   // pattern phase lengths in milliseconds
   // ****************************************************************
   localparam logic [10:0] T_200MS = 11'd200;
   localparam logic [10:0] T_300MS = 11'd300;
   localparam logic [10:0] T_500MS = 11'd500;
   localparam logic [10:0] T_1S = 11'd1000;

   // ****************************************************************
   // fieldbus slave states and lamp patterns
   // ****************************************************************
   typedef enum logic [1:0] {
      ILSEQ_INIT,
      ILSEQ_PRE_OPERATIONAL,
      ILSEQ_SAFE_OPERATIONAL,
      ILSEQ_OPERATIONAL
   } ilseq_bus_state_t;

   typedef enum logic [2:0] {
      ILSEQ_PAT_OFF,
      ILSEQ_PAT_ON,
      ILSEQ_PAT_BLINK_200,
      ILSEQ_PAT_SINGLE_FLASH,
      ILSEQ_PAT_DOUBLE_FLASH,
      ILSEQ_PAT_BLINK_300,
      ILSEQ_PAT_BLINK_500,
      ILSEQ_PAT_BLINK_1S
   } ilseq_pattern_t;

   // fault sources, index order is also the order of raising ties
   localparam int NUM_FAULTS = 7;
   localparam int F_TRANSITION = 0;
   localparam int F_RESYNC = 1;
   localparam int F_WATCHDOG = 2;
   localparam int F_FLASH_CSUM = 3;
   localparam int F_SENSOR = 4;
   localparam int F_DIG_OUT = 5;
   localparam int F_ANA_OUT = 6;

   // fault flags as they arrive from firmware and monitors
   typedef struct packed {
      logic transition_refused;
      logic resync_fault;
      logic watchdog_enabled;
      logic watchdog_timeout;
      logic flash_checksum_fail;
      logic sensor_defect;
      logic value_saturated;
      logic six_axis_overload;
      logic dout_driven_high;
      logic dout_at_ground;
      logic dout_driven_low;
      logic dout_above_3v;
      logic current_output_open;
      logic ana_driver_hot;
   } ilseq_faults_t;

   // lamp drives
   typedef struct packed {
      logic power_lamp;
      logic run_state_lamp;
      logic error_lamp;
      logic [1:0] bus_port_lamp;
   } ilseq_lamps_t;

endpackage : ilseq_pkg

/* hw/ilseq_top.sv */
// indicator lamp sequencer: power, run-state, error and bus-port lamps
// assumes all state and fault inputs are synchronous to clk, except the
// mode button and the two link activity pins, which are synchronised here
//
// Overview of operation
// - per bus state, power lamp on in init only; run lamp off/200ms blink/flash/on
// - bootloader active without bus: power lamp 300ms blink, run lamp off
// - refused state transition: error lamp blinks 200ms on/off, priority 1
// - resync drop to safe-operational fault: 200ms flash then 1s dark, priority 1
// - watchdog timeout when enabled: double 200ms flash then 1s dark, priority 1
// - sensor defect, saturation or six-axis overload: error lamp steady, priority 2
// - digital output short: error lamp blinks 500ms on/off, priority 3
// - open current output or hot analog driver: 1s on/off blink, priority 4
// - flash checksum failure in update: error lamp steady, priority 1
// - run lamp driven only on industrial ethernet variants
// - bus-port lamps show link activity or bus switched on, per variant
// - mode button clears latched fault indications no longer present
`timescale 1ns/100ps
module ilseq_top
   import ilseq_pkg::*;
#(
   parameter int TICK_COUNT = TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic has_ethernet_bus,
   input wire logic has_can_bus,
   input wire logic can_bus_enabled,
   input wire logic [1:0] link_activity,
   input wire logic bootloader_active,
   input wire ilseq_bus_state_t bus_state,
   input wire ilseq_faults_t faults,
   input wire logic mode_button,
   output ilseq_lamps_t lamps
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [16:0] tick_div;
      logic [1:0] btn_meta;
      logic [1:0] btn_sync;
      logic [1:0] link_meta;
      logic [1:0] link_sync;
      logic [NUM_FAULTS-1:0] latched;
      logic [2:0] shown;
      logic shown_valid;
      ilseq_pattern_t err_pat;
      logic [11:0] err_ms;
      ilseq_pattern_t run_pat;
      logic [11:0] run_ms;
      ilseq_pattern_t pwr_pat;
      logic [11:0] pwr_ms;
      ilseq_lamps_t lamps;
   } ilseq_state_t;

   ilseq_state_t st;
   ilseq_state_t next_st;

   // priority of each fault source, smaller shows first
   function automatic logic [2:0] fault_prio(input logic [2:0] idx);
      unique case (idx)
         3'h4: fault_prio = 3'h2;
         3'h5: fault_prio = 3'h3;
         3'h6: fault_prio = 3'h4;
         default: fault_prio = 3'h1;
      endcase
   endfunction : fault_prio

   // lamp pattern of each fault source
   function automatic ilseq_pattern_t fault_pattern(input logic [2:0] idx);
      unique case (idx)
         3'h0: fault_pattern = ILSEQ_PAT_BLINK_200;
         3'h1: fault_pattern = ILSEQ_PAT_SINGLE_FLASH;
         3'h2: fault_pattern = ILSEQ_PAT_DOUBLE_FLASH;
         3'h5: fault_pattern = ILSEQ_PAT_BLINK_500;
         3'h6: fault_pattern = ILSEQ_PAT_BLINK_1S;
         default: fault_pattern = ILSEQ_PAT_ON;
      endcase
   endfunction : fault_pattern

   // lamp level at millisecond position ms of pattern p
   function automatic logic pattern_level(input ilseq_pattern_t p, input logic [11:0] ms);
      unique case (p)
         ILSEQ_PAT_OFF: pattern_level = 1'b0;
         ILSEQ_PAT_ON: pattern_level = 1'b1;
         ILSEQ_PAT_BLINK_200: pattern_level = ms < {1'b0, T_200MS};
         ILSEQ_PAT_SINGLE_FLASH: pattern_level = ms < {1'b0, T_200MS};
         ILSEQ_PAT_DOUBLE_FLASH: pattern_level = (ms < {1'b0, T_200MS}) ||
            (ms >= {1'b0, T_200MS} + {1'b0, T_200MS} && ms < 12'd3 * {1'b0, T_200MS});
         ILSEQ_PAT_BLINK_300: pattern_level = ms < {1'b0, T_300MS};
         ILSEQ_PAT_BLINK_500: pattern_level = ms < {1'b0, T_500MS};
         ILSEQ_PAT_BLINK_1S: pattern_level = ms < {1'b0, T_1S};
      endcase
   endfunction : pattern_level

   // length of one whole period of pattern p in milliseconds
   function automatic logic [11:0] pattern_period(input ilseq_pattern_t p);
      unique case (p)
         ILSEQ_PAT_BLINK_200: pattern_period = {1'b0, T_200MS} + {1'b0, T_200MS};
         ILSEQ_PAT_SINGLE_FLASH: pattern_period = {1'b0, T_200MS} + {1'b0, T_1S};
         ILSEQ_PAT_DOUBLE_FLASH: pattern_period = 12'd3 * {1'b0, T_200MS} + {1'b0, T_1S};
         ILSEQ_PAT_BLINK_300: pattern_period = {1'b0, T_300MS} + {1'b0, T_300MS};
         ILSEQ_PAT_BLINK_500: pattern_period = {1'b0, T_500MS} + {1'b0, T_500MS};
         ILSEQ_PAT_BLINK_1S: pattern_period = {1'b0, T_1S} + {1'b0, T_1S};
         default: pattern_period = 12'h001;
      endcase
   endfunction : pattern_period

   // advance a pattern position; restart at zero when the pattern changes
   function automatic logic [11:0] advance(input ilseq_pattern_t old_p,
                                           input ilseq_pattern_t new_p,
                                           input logic [11:0] ms,
                                           input logic tick);
      if (old_p != new_p) begin
         advance = 12'h000;
      end else if (!tick) begin
         advance = ms;
      end else if (ms + 12'h001 >= pattern_period(new_p)) begin
         advance = 12'h000;
      end else begin
         advance = ms + 12'h001;
      end
   endfunction : advance

   // ****************************************************************
   // next-state logic
   // ****************************************************************
   logic [NUM_FAULTS-1:0] present;
   logic tick;
   logic [2:0] best;
   logic best_valid;
   ilseq_pattern_t next_run;
   ilseq_pattern_t next_pwr;
   ilseq_pattern_t next_err;

   always_comb begin
      next_st = st;
      present = '0;
      best = 3'h0;
      best_valid = 1'b0;
      next_run = ILSEQ_PAT_OFF;
      next_pwr = ILSEQ_PAT_OFF;
      next_err = ILSEQ_PAT_OFF;

      // millisecond timebase
      tick = (st.tick_div == 17'(TICK_COUNT - 1));
      next_st.tick_div = tick ? 17'h00000 : st.tick_div + 17'h00001;

      // two-stage synchronisers for the pin inputs
      next_st.btn_meta = {st.btn_meta[0], mode_button};
      next_st.btn_sync = {st.btn_sync[0], st.btn_meta[1]};
      next_st.link_meta = link_activity;
      next_st.link_sync = st.link_meta;

      // fault conditions as currently present
      present[F_TRANSITION] = faults.transition_refused;
      present[F_RESYNC] = faults.resync_fault;
      present[F_WATCHDOG] = faults.watchdog_enabled && faults.watchdog_timeout;
      present[F_FLASH_CSUM] = faults.flash_checksum_fail;
      present[F_SENSOR] = faults.sensor_defect || faults.value_saturated ||
                          faults.six_axis_overload;
      present[F_DIG_OUT] = (faults.dout_driven_high && faults.dout_at_ground) ||
                           (faults.dout_driven_low && faults.dout_above_3v);
      present[F_ANA_OUT] = faults.current_output_open || faults.ana_driver_hot;

      // latch faults; a button press drops only those gone, and a new fault wins
      if (st.btn_sync[0] && !st.btn_sync[1]) begin
         next_st.latched = present;
      end else begin
         next_st.latched = st.latched | present;
      end

      // pick the winner; a shown fault holds against equal priorities
      for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
         if (next_st.latched[i] &&
             (!best_valid || fault_prio(3'(i)) <= fault_prio(best))) begin
            best = 3'(i);
            best_valid = 1'b1;
         end
      end
      if (st.shown_valid && next_st.latched[st.shown] &&
          (!best_valid || fault_prio(st.shown) <= fault_prio(best))) begin
         best = st.shown;
      end
      next_st.shown = best;
      next_st.shown_valid = best_valid;
      if (best_valid) begin
         next_err = fault_pattern(best);
      end

      // power and run-state lamps follow bus state or bootloader
      if (bootloader_active) begin
         next_pwr = ILSEQ_PAT_BLINK_300;
      end else begin
         unique case (bus_state)
            ILSEQ_INIT: next_pwr = ILSEQ_PAT_ON;
            ILSEQ_PRE_OPERATIONAL: next_run = ILSEQ_PAT_BLINK_200;
            ILSEQ_SAFE_OPERATIONAL: next_run = ILSEQ_PAT_SINGLE_FLASH;
            ILSEQ_OPERATIONAL: next_run = ILSEQ_PAT_ON;
         endcase
      end
      if (!has_ethernet_bus) begin
         next_run = ILSEQ_PAT_OFF;
      end

      // pattern positions
      next_st.err_ms = advance(st.err_pat, next_err, st.err_ms, tick);
      next_st.run_ms = advance(st.run_pat, next_run, st.run_ms, tick);
      next_st.pwr_ms = advance(st.pwr_pat, next_pwr, st.pwr_ms, tick);
      next_st.err_pat = next_err;
      next_st.run_pat = next_run;
      next_st.pwr_pat = next_pwr;

      // registered lamp drives
      next_st.lamps.error_lamp = pattern_level(next_err, next_st.err_ms);
      next_st.lamps.run_state_lamp = pattern_level(next_run, next_st.run_ms);
      next_st.lamps.power_lamp = pattern_level(next_pwr, next_st.pwr_ms);
      if (has_ethernet_bus) begin
         next_st.lamps.bus_port_lamp = st.link_sync;
      end else if (has_can_bus) begin
         next_st.lamps.bus_port_lamp = {2{can_bus_enabled}};
      end else begin
         next_st.lamps.bus_port_lamp = 2'h0;
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   // one register for all state keeps reset handling in one place
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign lamps = st.lamps;

endmodule : ilseq_top

/* verification/ilseq_operator.sv */
// operator at the panel: times one lamp and presses the mode button
// assumes the lamp is a registered level that changes on rising clk edges
`timescale 1ns/100ps
module ilseq_operator (
   input wire logic clk,
   input wire logic lamp,
   output logic mode_button
);
   // ****************************************************************
   // button and lamp timing
   // ****************************************************************
   initial mode_button = 1'b0;
   // hold well past the synchroniser so the press is never missed
   task press();
      @(posedge clk);
      #1 mode_button = 1'b1;
      repeat (8) @(posedge clk);
      #1 mode_button = 1'b0;
      repeat (8) @(posedge clk);
   endtask : press
   // bounded wait; a stuck lamp returns a huge count, never a hang
   // the lamp is read just after the edge, once its new level has settled
   task wait_lvl(input logic v, output int n);
      n = 0;
      while (lamp !== v && n < 20000) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : wait_lvl
   // a restart may cut the first on-phase short, so it is skipped whole
   task phase(output logic [31:0] on_sum, output logic [31:0] off_sum);
      int n;
      on_sum = 0;
      off_sum = 0;
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, n);
      repeat (2) begin
         wait_lvl(1'b1, n);
         off_sum += n;
         wait_lvl(1'b0, n);
         on_sum += n;
      end
   endtask : phase
endmodule : ilseq_operator

/* verification/ilseq_top_sva.sv */
// assertions on the lamp drives of the sequencer top
// assumes one clock domain and the async active high reset of the top
`timescale 1ns/100ps
module ilseq_sva
   import ilseq_pkg::*;
#(
   parameter int TICK_COUNT = TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic has_ethernet_bus,
   input wire logic has_can_bus,
   input wire logic can_bus_enabled,
   input wire logic [1:0] link_activity,
   input wire logic bootloader_active,
   input wire ilseq_bus_state_t bus_state,
   input wire ilseq_faults_t faults,
   input wire logic mode_button,
   input wire ilseq_lamps_t lamps
);
   // ****************************************************************
   // properties
   // ****************************************************************
   localparam int PW_MAX = 300 * TICK_COUNT + 2;
   int pw_cnt;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   // on-phase length of the power lamp while the bootloader runs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) pw_cnt <= 0;
      else pw_cnt <= (lamps.power_lamp && bootloader_active) ? pw_cnt + 1 : 0;
   end
   AST_POWER_INIT: assert property (
      (!bootloader_active && bus_state == ILSEQ_INIT) |=> lamps.power_lamp)
      else $error("power lamp dark in init");
   AST_POWER_OFF: assert property (
      (!bootloader_active && bus_state != ILSEQ_INIT) |=> !lamps.power_lamp)
      else $error("power lamp lit outside init");
   AST_RUN_OP: assert property (
      (has_ethernet_bus && !bootloader_active && bus_state == ILSEQ_OPERATIONAL)
      |=> lamps.run_state_lamp) else $error("run lamp dark when operational");
   AST_RUN_IDLE: assert property (
      (bootloader_active || bus_state == ILSEQ_INIT) |=> !lamps.run_state_lamp)
      else $error("run lamp lit in init or boot");
   AST_RUN_NO_ETH: assert property (!has_ethernet_bus |=> !lamps.run_state_lamp)
      else $error("run lamp lit without ethernet");
   AST_BOOT_BLINK: assert property (pw_cnt <= PW_MAX)
      else $error("boot power on-phase too long");
   AST_PORT_CAN: assert property (
      (!has_ethernet_bus && has_can_bus)
      |=> lamps.bus_port_lamp == {2{$past(can_bus_enabled)}})
      else $error("port lamps differ from bus enable");
   AST_PORT_NONE: assert property (
      (!has_ethernet_bus && !has_can_bus) |=> lamps.bus_port_lamp == 2'h0)
      else $error("port lamps lit without bus");
   AST_PORT_ETH: assert property (
      has_ethernet_bus [*4] |-> lamps.bus_port_lamp == $past(link_activity, 3))
      else $error("port lamps differ from link activity");
   cover property ($rose(lamps.error_lamp));
   cover property (bootloader_active && $fell(lamps.power_lamp));
   cover property ($rose(mode_button));
endmodule : ilseq_sva
bind ilseq_top ilseq_sva #(.TICK_COUNT(TICK_COUNT)) chk (.clk(clk), .reset(reset),
   .has_ethernet_bus(has_ethernet_bus), .has_can_bus(has_can_bus),
   .can_bus_enabled(can_bus_enabled), .link_activity(link_activity),
   .bootloader_active(bootloader_active), .bus_state(bus_state), .faults(faults),
   .mode_button(mode_button), .lamps(lamps));

/* verification/ilseq_top_tb.sv */
// self-checking bench for the lamp sequencer with an operator model
// assumes a two-cycle tick so the slow patterns fit a short run
`timescale 1ns/100ps
module ilseq_top_tb;
   import ilseq_pkg::*;
   // ****************************************************************
   // stimulus, model and checks
   // ****************************************************************
   localparam int TK = 2;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic has_ethernet_bus = 1'b1;
   logic has_can_bus = 1'b0;
   logic can_bus_enabled = 1'b0;
   logic [1:0] link_activity = 2'h0;
   logic bootloader_active = 1'b0;
   ilseq_bus_state_t bus_state = ILSEQ_INIT;
   ilseq_faults_t faults = '0;
   logic mode_button;
   ilseq_lamps_t lamps;
   logic [1:0] sel = 2'h2;
   logic [31:0] on_sum;
   logic [31:0] off_sum;
   logic [31:0] rnd = 32'h0000005c;
   logic [1:0] exp_port;
   int err_count = 0;
   int compares = 0;
   // expected on time of one phase and off time summed over two off phases, per fault mask
   int on_ms[7] = '{200, 200, 200, 500, 500, 1000, 1000};
   int off_ms[7] = '{400, 2000, 1200, 1000, 1000, 2000, 2000};
   logic [13:0] mask[7] = '{14'h2000, 14'h1000, 14'h0c00, 14'h0030, 14'h000c,
      14'h0002, 14'h0001};
   wire logic seen = (sel == 2'h0) ? lamps.power_lamp :
      (sel == 2'h1) ? lamps.run_state_lamp : lamps.error_lamp;
   always #5 clk = ~clk;
   ilseq_top #(.TICK_COUNT(TK)) dut (.clk(clk), .reset(reset),
      .has_ethernet_bus(has_ethernet_bus), .has_can_bus(has_can_bus),
      .can_bus_enabled(can_bus_enabled), .link_activity(link_activity),
      .bootloader_active(bootloader_active), .bus_state(bus_state), .faults(faults),
      .mode_button(mode_button), .lamps(lamps));
   ilseq_operator op (.clk(clk), .lamp(seen), .mode_button(mode_button));
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction : xs
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task results();
      $display("mismatches %0d comparisons %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results
   task cmp_len(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_len
   task cmp_lvl(input logic [1:0] got, input logic [1:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_lvl
   // times two on and two off phases of the chosen lamp; a stuck lamp ends the run
   task measure(input logic [1:0] s, input int on, input int off);
      sel = s;
      op.phase(on_sum, off_sum);
      cmp_len(on_sum, 2 * on * TK);
      cmp_len(off_sum, off * TK);
      if (on_sum >= 20000 || off_sum >= 20000) results();
   endtask : measure
   // samples span 700 ms, more than a 500 ms on-phase, so that blink cannot pass, but a 1 s blink can
   task steady();
      repeat (3) begin
         step(700);
         cmp_lvl({1'b0, lamps.error_lamp}, 2'h1);
      end
   endtask : steady
   task clear();
      faults = '0;
      op.press();
      step(1);
      cmp_lvl({1'b0, lamps.error_lamp}, 2'h0);
   endtask : clear
   initial begin
      step(8);
      reset = 1'b0;
      step(2);
      cmp_lvl({lamps.power_lamp, lamps.run_state_lamp}, 2'h2);
      bus_state = ILSEQ_PRE_OPERATIONAL;
      measure(2'h1, 200, 400);
      bus_state = ILSEQ_SAFE_OPERATIONAL;
      measure(2'h1, 200, 2000);
      bus_state = ILSEQ_OPERATIONAL;
      step(2);
      cmp_lvl({lamps.power_lamp, lamps.run_state_lamp}, 2'h1);
      bootloader_active = 1'b1;
      measure(2'h0, 300, 600);
      cmp_lvl({1'b0, lamps.run_state_lamp}, 2'h0);
      bootloader_active = 1'b0;
      for (int k = 0; k < 7; k++) begin
         faults = ilseq_faults_t'(mask[k]);
         measure(2'h2, on_ms[k], off_ms[k]);
         clear();
      end
      faults = ilseq_faults_t'(14'h0101);
      steady();
      faults = ilseq_faults_t'(14'h1101);
      measure(2'h2, 200, 2000);
      // a later transition fault of equal priority must not displace resync
      faults = ilseq_faults_t'(14'h3101);
      measure(2'h2, 200, 2000);
      faults = ilseq_faults_t'(14'h0040);
      op.press();
      steady();
      faults = ilseq_faults_t'(14'h0080);
      steady();
      clear();
      faults = ilseq_faults_t'(14'h0200);
      steady();
      clear();
      // timeout without watchdog, high output at 3 V: neither is a fault
      faults = ilseq_faults_t'(14'h0424);
      step(50);
      cmp_lvl({1'b0, lamps.error_lamp}, 2'h0);
      faults = '0;
      for (int v = 0; v < 8; v++) begin
         rnd = xs(rnd);
         has_ethernet_bus = rnd[4];
         has_can_bus = rnd[3];
         can_bus_enabled = rnd[2];
         link_activity = rnd[1:0];
         exp_port = rnd[4] ? rnd[1:0] : (rnd[3] ? {2{rnd[2]}} : 2'h0);
         step(5);
         cmp_lvl(lamps.bus_port_lamp, exp_port);
         cmp_lvl({1'b0, lamps.run_state_lamp}, {1'b0, rnd[4]});
      end
      results();
   end
endmodule : ilseq_top_tb
